/* core/osdps_pkg.sv */
/*
 * osdps_pkg: constants shared by the output pin select block.
 * assumes: single 25 MHz clock domain, synchronous active-high reset.
 */
package osdps_pkg;

    // pin mode encoding held in the configuration bit
    typedef enum logic [0:0] {
        OSDPS_MODE_AUX = 1'h0,   // rgb + two auxiliary character channels
        OSDPS_MODE_RGB = 1'h1    // rgb + per-colour blanking
    } osdps_mode_t;

    localparam osdps_mode_t OSDPS_MODE_RESET = OSDPS_MODE_AUX;

    // output bus bit positions
    localparam int unsigned OSDPS_PIN_AUX_BLANK_A = 0;
    localparam int unsigned OSDPS_PIN_AUX_CHAR_A  = 1;
    localparam int unsigned OSDPS_PIN_SHARED_BLK  = 2;
    localparam int unsigned OSDPS_PIN_SHARED_CHR  = 3;
    localparam int unsigned OSDPS_PIN_RGB_BLANK   = 4;
    localparam int unsigned OSDPS_PIN_RED_CHAR    = 5;
    localparam int unsigned OSDPS_PIN_GREEN_CHAR  = 6;
    localparam int unsigned OSDPS_PIN_BLUE_CHAR   = 7;
    localparam int unsigned OSDPS_PIN_COUNT       = 8;

    // sync inputs are negative going: active level
    localparam logic OSDPS_SYNC_ACTIVE = 1'h0;

endpackage

/* core/osdps_sync_pol.sv */
/*
 * osdps_sync_pol: turns negative-going sync inputs into active-high
 * pulses and registers them.
 * assumes: sync inputs already synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module osdps_sync_pol (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // sync in, negative polarity
    input  wire logic sync_n_i,
    // sync out, active high
    output logic      sync_o
);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sync_o <= 1'h0;
        end else begin
            sync_o <= (sync_n_i == osdps_pkg::OSDPS_SYNC_ACTIVE);
        end
    end

endmodule

`default_nettype wire

/* core/osdps_top.sv */
/*
 * osdps_top: output pin assignment of the on-screen display.
 * maps internal character and blanking signals onto eight pins in
 * one of two pin modes and registers every pin.
 * a mode write shows on mode_rgb_o one edge later and on the pins
 * two edges later; the colour pins never depend on the mode, so a
 * switch leaves them untouched.
 * assumes: all inputs synchronous to clk_i; the command decoder
 * delivers a one-cycle mode write strobe.
 */
// What this block does
// - default mode: aux_blank_a is active-high blanking
// - rgb mode: aux_blank_a ORs three colour blanks
// - aux_char_a high-active; rgb mode ORs colours
// - default mode: shared pin is aux_blank_b
// - rgb mode: shared pin becomes red_blank
// - shared pin: aux_char_b or green_blank
// - default mode: rgb_blank covers all colours
// - rgb mode: rgb_blank pin becomes blue_blank
// - test pin low keeps test mode off
// - reset selects two-channel auxiliary mode
`timescale 1ns/1ps
`default_nettype none

module osdps_top (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // mode command from the command decoder
    input  wire logic mode_wr_i,
    input  wire logic mode_rgb_i,
    // test strap
    input  wire logic test_i,
    // sync inputs, negative polarity
    input  wire logic vsync_n_i,
    input  wire logic hsync_n_i,
    // internal character sources
    input  wire logic red_char_i,
    input  wire logic green_char_i,
    input  wire logic blue_char_i,
    input  wire logic aux_char_a_i,
    input  wire logic aux_char_b_i,
    // internal blanking sources
    input  wire logic rgb_blank_i,
    input  wire logic aux_blank_a_i,
    input  wire logic aux_blank_b_i,
    input  wire logic red_blank_i,
    input  wire logic green_blank_i,
    input  wire logic blue_blank_i,
    // output pins
    output logic      aux_blank_a_o,
    output logic      aux_char_a_o,
    output logic      shared_blank_o,
    output logic      shared_char_o,
    output logic      rgb_blank_o,
    output logic      red_char_o,
    output logic      green_char_o,
    output logic      blue_char_o,
    // status
    output logic      mode_rgb_o,
    output logic      test_mode_o,
    output logic      vsync_o,
    output logic      hsync_o
);

    ////////////////////////////////////////////////////////////////////////

    osdps_pkg::osdps_mode_t                mode_q;
    logic                                  mode_rgb_q;
    logic                                  any_blank;
    logic                                  any_char;
    logic [osdps_pkg::OSDPS_PIN_COUNT-1:0] pins_d;
    logic [osdps_pkg::OSDPS_PIN_COUNT-1:0] pins_q;

    // three-way merge, shared by the blank and the character pin in rgb mode
    function automatic logic osdps_or3(
        input logic a_i,
        input logic b_i,
        input logic c_i
    );
        return a_i | b_i | c_i;
    endfunction

    ////////////////////////////////////////////////////////////////////////

    // mode bit, reset to the auxiliary mapping
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mode_q <= osdps_pkg::OSDPS_MODE_RESET;
        end else if (mode_wr_i) begin
            mode_q <= mode_rgb_i ? osdps_pkg::OSDPS_MODE_RGB : osdps_pkg::OSDPS_MODE_AUX;
        end
    end

    // status copy of the mode bit in a flop of its own, so the status pin
    // has no gate between flop and pad
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mode_rgb_q <= (osdps_pkg::OSDPS_MODE_RESET == osdps_pkg::OSDPS_MODE_RGB);
        end else if (mode_wr_i) begin
            mode_rgb_q <= mode_rgb_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    // merged colour signals; the or sits before the pin register so the
    // pins cannot glitch while the three sources settle
    always_comb begin
        any_blank = osdps_or3(
            red_blank_i,
            green_blank_i,
            blue_blank_i
        );
        any_char = osdps_or3(
            red_char_i,
            green_char_i,
            blue_char_i
        );
    end

    ////////////////////////////////////////////////////////////////////////

    // pin mapping; colour pins are the same in both modes
    always_comb begin
        pins_d = '0;
        pins_d[osdps_pkg::OSDPS_PIN_RED_CHAR]   = red_char_i;
        pins_d[osdps_pkg::OSDPS_PIN_GREEN_CHAR] = green_char_i;
        pins_d[osdps_pkg::OSDPS_PIN_BLUE_CHAR]  = blue_char_i;
        case (mode_q)
            osdps_pkg::OSDPS_MODE_AUX: begin
                pins_d[osdps_pkg::OSDPS_PIN_AUX_BLANK_A] = aux_blank_a_i;
                pins_d[osdps_pkg::OSDPS_PIN_AUX_CHAR_A]  = aux_char_a_i;
                pins_d[osdps_pkg::OSDPS_PIN_SHARED_BLK]  = aux_blank_b_i;
                pins_d[osdps_pkg::OSDPS_PIN_SHARED_CHR]  = aux_char_b_i;
                pins_d[osdps_pkg::OSDPS_PIN_RGB_BLANK]   = rgb_blank_i;
            end
            osdps_pkg::OSDPS_MODE_RGB: begin
                pins_d[osdps_pkg::OSDPS_PIN_AUX_BLANK_A] = any_blank;
                pins_d[osdps_pkg::OSDPS_PIN_AUX_CHAR_A]  = any_char;
                pins_d[osdps_pkg::OSDPS_PIN_SHARED_BLK]  = red_blank_i;
                pins_d[osdps_pkg::OSDPS_PIN_SHARED_CHR]  = green_blank_i;
                pins_d[osdps_pkg::OSDPS_PIN_RGB_BLANK]   = blue_blank_i;
            end
            default: begin
                pins_d = '0;
            end
        endcase
    end

    // registering every pin keeps the mux switch from glitching the pads
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pins_q <= '0;
        end else begin
            pins_q <= pins_d;
        end
    end

    always_comb begin
        aux_blank_a_o  = pins_q[osdps_pkg::OSDPS_PIN_AUX_BLANK_A];
        aux_char_a_o   = pins_q[osdps_pkg::OSDPS_PIN_AUX_CHAR_A];
        shared_blank_o = pins_q[osdps_pkg::OSDPS_PIN_SHARED_BLK];
        shared_char_o  = pins_q[osdps_pkg::OSDPS_PIN_SHARED_CHR];
        rgb_blank_o    = pins_q[osdps_pkg::OSDPS_PIN_RGB_BLANK];
        red_char_o     = pins_q[osdps_pkg::OSDPS_PIN_RED_CHAR];
        green_char_o   = pins_q[osdps_pkg::OSDPS_PIN_GREEN_CHAR];
        blue_char_o    = pins_q[osdps_pkg::OSDPS_PIN_BLUE_CHAR];
        mode_rgb_o     = mode_rgb_q;
    end

    ////////////////////////////////////////////////////////////////////////

    // test mode only while the strap is high; low means normal use
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            test_mode_o <= 1'h0;
        end else begin
            test_mode_o <= test_i;
        end
    end

    // sync polarity: inputs are expected active low
    osdps_sync_pol u_vsync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .sync_n_i  (vsync_n_i),
        .sync_o    (vsync_o)
    );

    osdps_sync_pol u_hsync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .sync_n_i  (hsync_n_i),
        .sync_o    (hsync_o)
    );

endmodule

`default_nettype wire

/* dv/osdps_sync_src.sv */
/* osdps_sync_src: camera sync source and board test strap.
   assumes: one clock shared with the block under test. */
`timescale 1ns/1ps
`default_nettype none
module osdps_sync_src (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    output logic      vsync_n_o,
    output logic      hsync_n_o,
    output logic      test_o
);
    logic [8:0] cnt_q;
    always_ff @(posedge clk_i) cnt_q <= sys_rst_i ? 9'h000 : cnt_q + 9'h001;
    // short lines keep the run brief
    assign hsync_n_o = cnt_q[4:2] != 3'h0;
    assign vsync_n_o = cnt_q[8:5] != 4'h0;
    assign test_o    = 1'h0;
endmodule
`default_nettype wire

/* dv/osdps_top_properties.sv */
/* osdps_chk: pin mapping checks for osdps_top.
   assumes: bound to osdps_top, one clock. */
`timescale 1ns/1ps
`default_nettype none
module osdps_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // mode command and status
    input wire logic mode_wr_i,
    input wire logic mode_rgb_i,
    input wire logic mode_rgb_o,
    // blanking sources
    input wire logic red_blank_i,
    input wire logic green_blank_i,
    input wire logic blue_blank_i,
    input wire logic aux_blank_a_i,
    input wire logic aux_blank_b_i,
    input wire logic rgb_blank_i,
    // character sources
    input wire logic red_char_i,
    input wire logic green_char_i,
    input wire logic blue_char_i,
    input wire logic aux_char_a_i,
    input wire logic aux_char_b_i,
    // mode dependent pins
    input wire logic aux_blank_a_o,
    input wire logic aux_char_a_o,
    input wire logic shared_blank_o,
    input wire logic shared_char_o,
    input wire logic rgb_blank_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // a write reaches the pins two edges later; writes under reset are dropped
    sequence s_to_rgb;
        !sys_rst_i && mode_wr_i && mode_rgb_i ##1 1'b1;
    endsequence
    // one pin sample taken outside reset, in either mapping
    sequence s_aux;
        !sys_rst_i && !mode_rgb_o;
    endsequence
    sequence s_rgb;
        !sys_rst_i && mode_rgb_o;
    endsequence
    mode_take_a: assert property (!sys_rst_i && mode_wr_i |=> mode_rgb_o == $past(mode_rgb_i))
        else $error("mode not taken");
    reset_aux_a: assert property ($fell(sys_rst_i) |-> !mode_rgb_o)
        else $error("mode not aux after reset");
    blank_a_aux_a: assert property (s_aux |=> aux_blank_a_o == $past(aux_blank_a_i))
        else $error("aux blank a wrong");
    blank_a_or_a: assert property (s_rgb |=> aux_blank_a_o ==
        ($past(red_blank_i) | $past(green_blank_i) | $past(blue_blank_i))) else $error("blank or wrong");
    char_a_or_a: assert property (s_rgb |=> aux_char_a_o ==
        ($past(red_char_i) | $past(green_char_i) | $past(blue_char_i))) else $error("char or wrong");
    char_a_aux_a: assert property (s_aux |=> aux_char_a_o == $past(aux_char_a_i))
        else $error("aux char a wrong");
    aux_blank_b_a: assert property (s_aux |=> shared_blank_o == $past(aux_blank_b_i))
        else $error("aux blank b wrong");
    red_blank_a: assert property (s_rgb |=> shared_blank_o == $past(red_blank_i))
        else $error("red blank wrong");
    aux_char_b_a: assert property (s_aux |=> shared_char_o == $past(aux_char_b_i))
        else $error("aux char b wrong");
    green_blank_a: assert property (s_rgb |=> shared_char_o == $past(green_blank_i))
        else $error("green blank wrong");
    rgb_blank_aux_a: assert property (s_aux |=> rgb_blank_o == $past(rgb_blank_i))
        else $error("rgb blank wrong");
    blue_blank_a: assert property (s_to_rgb |=> rgb_blank_o == $past(blue_blank_i))
        else $error("blue blank wrong");
    blue_pin_rgb_a: assert property (s_rgb |=> rgb_blank_o == $past(blue_blank_i))
        else $error("blue pin wrong");
endmodule
bind osdps_top osdps_chk i_chk (
    .clk_i          (clk_i),
    .sys_rst_i      (sys_rst_i),
    .mode_wr_i      (mode_wr_i),
    .mode_rgb_i     (mode_rgb_i),
    .mode_rgb_o     (mode_rgb_o),
    .red_blank_i    (red_blank_i),
    .green_blank_i  (green_blank_i),
    .blue_blank_i   (blue_blank_i),
    .aux_blank_a_i  (aux_blank_a_i),
    .aux_blank_b_i  (aux_blank_b_i),
    .rgb_blank_i    (rgb_blank_i),
    .red_char_i     (red_char_i),
    .green_char_i   (green_char_i),
    .blue_char_i    (blue_char_i),
    .aux_char_a_i   (aux_char_a_i),
    .aux_char_b_i   (aux_char_b_i),
    .aux_blank_a_o  (aux_blank_a_o),
    .aux_char_a_o   (aux_char_a_o),
    .shared_blank_o (shared_blank_o),
    .shared_char_o  (shared_char_o),
    .rgb_blank_o    (rgb_blank_o)
);
`default_nettype wire

/* dv/testbench.sv */
/* testbench: sweeps osdps_top through both pin modes.
   assumes: osdps_sync_src drives sync and test strap. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_i = 1'h0, sys_rst_i = 1'h1, mode_wr_i = 1'h0, mode_rgb_i = 1'h0;
    logic [10:0] src = 11'h000;
    logic [2:0]  prev = 3'h0;
    wire logic [2:0] st;
    wire logic [7:0] p;
    wire logic   md, tm, vs, hs;
    int          n_fail = 0, samples_checked = 0, cyc = 0;
    always #20 clk_i = ~clk_i;
    osdps_sync_src i_src (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .vsync_n_o(st[2]), .hsync_n_o(st[1]), .test_o(st[0]));
    osdps_top i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .mode_wr_i(mode_wr_i), .mode_rgb_i(mode_rgb_i),
        .test_i(st[0]), .vsync_n_i(st[2]), .hsync_n_i(st[1]), .red_char_i(src[0]), .green_char_i(src[1]),
        .blue_char_i(src[2]), .aux_char_a_i(src[3]), .aux_char_b_i(src[4]), .rgb_blank_i(src[5]),
        .aux_blank_a_i(src[6]), .aux_blank_b_i(src[7]), .red_blank_i(src[8]), .green_blank_i(src[9]),
        .blue_blank_i(src[10]), .aux_blank_a_o(p[0]), .aux_char_a_o(p[1]), .shared_blank_o(p[2]),
        .shared_char_o(p[3]), .rgb_blank_o(p[4]), .red_char_o(p[5]), .green_char_o(p[6]), .blue_char_o(p[7]),
        .mode_rgb_o(md), .test_mode_o(tm), .vsync_o(vs), .hsync_o(hs));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ceiling well above the two sweeps of about 8200 cycles
    always @(posedge clk_i) begin
        prev <= st;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic set_mode(input logic m);
        @(posedge clk_i) {mode_wr_i, mode_rgb_i} <= {1'h1, m};
        @(posedge clk_i) mode_wr_i <= 1'h0;
        #1 chk({7'h00, md}, {7'h00, m});
        @(posedge clk_i);
    endtask
    task automatic t_sweep(input logic m);
        logic [10:0] v;
        logic [7:0]  e;
        set_mode(m);
        for (int i = 0; i < 2048; i++) begin
            v = i[10:0];
            e = m ? {v[2:0], v[10:8], |v[2:0], |v[10:8]} : {v[2:0], v[5], v[4], v[7], v[3], v[6]};
            @(posedge clk_i) src <= v;
            @(posedge clk_i) #1;
            chk(p, e);
            chk({5'h00, vs, hs, tm}, {5'h00, ~prev[2:1], prev[0]});
        end
    endtask
    task automatic t_back_to_back;
        // entered in rgb mode: aux then rgb, so both writes change the bit
        @(posedge clk_i) {mode_wr_i, mode_rgb_i} <= 2'h2;
        @(posedge clk_i) mode_rgb_i <= 1'h1;
        #1 chk({7'h00, md}, 8'h00);
        chk({5'h00, p[7:5]}, 8'h07);
        @(posedge clk_i) mode_wr_i <= 1'h0;
        #1 chk({7'h00, md}, 8'h01);
        chk({5'h00, p[7:5]}, 8'h07);
    endtask
    task automatic t_reset_mid;
        set_mode(1'h1);
        @(posedge clk_i) {sys_rst_i, mode_wr_i, mode_rgb_i, src} <= {3'h7, 11'h7C0};
        @(posedge clk_i);
        @(posedge clk_i) {sys_rst_i, mode_wr_i} <= 2'h0;
        #1 chk({7'h00, md}, 8'h00);
        chk(p, 8'h00);
        // first edge after release: aux mapping of 7C0 is 05, rgb would give 1D
        @(posedge clk_i) #1;
        chk({7'h00, md}, 8'h00);
        chk(p, 8'h05);
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'h0;
        #1 chk({7'h00, md}, 8'h00);
        t_sweep(1'h0);
        t_sweep(1'h1);
        t_back_to_back();
        t_reset_mid();
        end_of_test();
    end
endmodule
`default_nettype wire
